// >>> rtl/wsb_bat.sv
// Battery-backed reset flag and the two low-battery flags
`timescale 1ns/1ps
`default_nettype none
module wsb_bat (
  // Clock and battery-side reset
  input wire logic i_sys_clk,
  input wire logic i_vbat_rst,
  // Power and comparator events
  input wire logic i_standby_on,
  input wire logic i_standby_rise,
  input wire logic i_main_rise,
  input wire logic i_bat_swap,
  input wire logic i_below_low,
  input wire logic i_below_high,
  input wire logic i_ec_por_clr,
  // Register side
  wsb_bat_if.bat bus
);
  import wsb_pkg::*;
  logic por_q;
  logic wake_low_q;
  logic smi_low_q;
  logic swap_hit;
  logic por_set;
  assign swap_hit = i_bat_swap & ~i_standby_on;
  assign por_set = swap_hit | (i_standby_rise & i_below_low);
  // Not on system reset: must survive standby cycles
  // persistent flag
  always_ff @(posedge i_sys_clk or posedge i_vbat_rst)
    if (i_vbat_rst)
      por_q <= RST_POR_FLAG;
    else if (por_set)
      por_q <= 1'b1;
    else if (i_ec_por_clr)
      por_q <= 1'b0;
  always_ff @(posedge i_sys_clk or posedge i_vbat_rst)
    if (i_vbat_rst)
    begin
      wake_low_q <= RST_LOW_FLAG;
      smi_low_q <= RST_LOW_FLAG;
    end
    else if (i_standby_rise)
    begin
      wake_low_q <= por_q | por_set;
      smi_low_q <= por_q | por_set;
    end
    else
    begin
      wake_low_q <= (i_main_rise & i_below_high) |
        (wake_low_q & ~bus.wake_low_clr);
      smi_low_q <= (i_main_rise & i_below_high) |
        (smi_low_q & ~bus.smi_low_clr);
    end
  assign bus.por_flag = por_q;
  assign bus.wake_low = wake_low_q;
  assign bus.smi_low = smi_low_q;
endmodule
`default_nettype wire

// >>> rtl/wsb_bat_if.sv
// Carrier between register logic and battery-backed status logic
`timescale 1ns/1ps
`default_nettype none
interface wsb_bat_if;
  logic wake_low_clr;
  logic smi_low_clr;
  logic wake_low;
  logic smi_low;
  logic por_flag;
  modport regs (output wake_low_clr, output smi_low_clr,
    input wake_low, input smi_low, input por_flag);
  modport bat (input wake_low_clr, input smi_low_clr,
    output wake_low, output smi_low, output por_flag);
endinterface
`default_nettype wire

// >>> rtl/wsb_irq_out.sv
// One host interrupt: open-drain pin and serial-interrupt level
`timescale 1ns/1ps
`default_nettype none
module wsb_irq_out (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Request and routing
  input wire logic i_req,
  input wire logic i_pin_en,
  input wire logic i_serirq_en,
  // Outputs
  output logic o_pin_o,
  output logic o_pin_oe,
  output logic o_serirq_n
);
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      o_pin_oe <= 1'b0;
      o_serirq_n <= 1'b1;
    end
    else
    begin
      o_pin_oe <= i_req & i_pin_en;
      o_serirq_n <= ~(i_req & i_serirq_en);
    end
  // Open drain only ever pulls low
  assign o_pin_o = 1'b0;
endmodule
`default_nettype wire

// >>> rtl/wsb_pkg.sv
// Constants for the wake, system-management and battery-status block
package wsb_pkg;
  localparam logic [5:0] OFS_WAKE_SUM = 6'h00;
  localparam logic [5:0] OFS_WAKE_GEN = 6'h01;
  localparam logic [5:0] OFS_WAKE_STS1 = 6'h02;
  localparam logic [5:0] OFS_WAKE_STS2 = 6'h03;
  localparam logic [5:0] OFS_WAKE_STS3 = 6'h04;
  localparam logic [5:0] OFS_WAKE_EN1 = 6'h05;
  localparam logic [5:0] OFS_WAKE_EN2 = 6'h06;
  localparam logic [5:0] OFS_WAKE_EN3 = 6'h07;
  localparam logic [5:0] OFS_SMI_SUM = 6'h10;
  localparam logic [5:0] OFS_SMI_GEN = 6'h11;
  localparam logic [5:0] OFS_SYSMGMT_STATUS_FIRST = 6'h12;
  localparam logic [5:0] OFS_SYSMGMT_STATUS_SECOND = 6'h13;
  localparam logic [5:0] OFS_SYSMGMT_STATUS_THIRD = 6'h14;
  localparam logic [5:0] OFS_SYSMGMT_ENABLE_FIRST = 6'h15;
  localparam logic [5:0] OFS_SYSMGMT_ENABLE_SECOND = 6'h16;
  localparam logic [5:0] OFS_SYSMGMT_ENABLE_THIRD = 6'h17;
  localparam logic [5:0] OFS_DISK_CHG = 6'h20;
  localparam logic [5:0] OFS_FW_STS = 6'h30;
  localparam logic [5:0] OFS_FW_EN = 6'h31;
  localparam int BIT_SUM = 0;
  localparam int BIT_LOW_BAT = 5;
  localparam int BIT_WDT = 1;
  localparam int BIT_PIN_EN = 7;
  localparam int BIT_SERIRQ_EN = 6;
  localparam int BIT_TO_WAKE = 5;
  localparam logic [7:0] MASK_WAKE_STS1 = 8'h3e;
  localparam logic [7:0] MASK_WAKE_STS2 = 8'h23;
  localparam logic [7:0] MASK_SYSMGMT_STATUS_SECOND = 8'h21;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic RST_POR_FLAG = 1'b1;
  localparam logic RST_LOW_FLAG = 1'b0;
  localparam logic [9:0] WINDOW_HIGH = 10'h000;
endpackage

// >>> rtl/wsb_top.sv
// Runtime wake and system-management event registers with battery flags
`timescale 1ns/1ps
`default_nettype none
module wsb_top (
  // Clock and resets
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_legacy_io_reset_n,
  input wire logic i_vbat_rst,
  // Host I/O access
  input wire logic [15:0] i_base_addr,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_rvalid,
  // Power rails and battery comparators
  input wire logic i_standby_on,
  input wire logic i_standby_rise,
  input wire logic i_main_on,
  input wire logic i_main_rise,
  input wire logic i_bat_swap,
  input wire logic i_below_low,
  input wire logic i_below_high,
  // Event sources
  input wire logic [4:0] i_wake_src,
  input wire logic [7:0] i_gpio_evt,
  input wire logic i_wdt_evt,
  input wire logic i_intrusion,
  input wire logic i_mailbox_event_one,
  input wire logic i_mailbox_event_two,
  input wire logic [4:0] i_sio_smi,
  input wire logic [7:0] i_fw_event_set,
  // Embedded controller side
  input wire logic i_ec_por_clr,
  output logic o_ec_por_flag,
  output logic [7:0] o_force_disk_change,
  // Host interrupt outputs
  output logic o_wake_event_pin_n_o,
  output logic o_wake_event_pin_n_oe,
  output logic o_sysmgmt_irq_pin_n_o,
  output logic o_sysmgmt_irq_pin_n_oe,
  output logic [1:0] o_serirq_n
);
  import wsb_pkg::*;

  wsb_bat_if bat_bus ();

  logic [15:0] ofs_full;
  logic [5:0] ofs;
  logic hit;
  logic [7:0] wd;
  logic wake_summary_flag_q;
  logic wake_pin_enable_q;
  logic [7:0] wake_sts1_q;
  logic wake_wdt_q;
  logic [7:0] wake_sts3_q;
  logic [7:0] wake_en1_q;
  logic [7:0] wake_en2_q;
  logic [7:0] wake_en3_q;
  logic smi_sum_q;
  logic [7:0] smi_gen_q;
  logic smi_wdt_q;
  logic [7:0] sysmgmt_status_third_q;
  logic [7:0] sysmgmt_enable_first_q;
  logic [7:0] sysmgmt_enable_second_q;
  logic [7:0] sysmgmt_enable_third_q;
  logic [7:0] fw_sts_q;
  logic [7:0] fw_en_q;
  logic [7:0] disk_chg_q;
  logic [4:0] wake_src_prev_q;
  logic [7:0] gpio_prev_q;
  logic wdt_prev_q;
  logic [4:0] wake_rise;
  logic [7:0] gpio_rise;
  logic wdt_rise;
  logic firmware_event_line;
  logic [7:0] wake_sts2;
  logic [7:0] wake_sts2_evt;
  logic [7:0] sysmgmt_status_first;
  logic [7:0] sysmgmt_status_second;
  logic [7:0] sysmgmt_status_second_evt;
  logic wake_pend;
  logic smi_pend;
  logic smi_group;
  logic disk_rst;
  logic [7:0] rdata_d;

  assign ofs_full = i_io_addr - i_base_addr;
  assign hit = (ofs_full[15:6] == WINDOW_HIGH);
  assign ofs = ofs_full[5:0];
  assign wd = i_io_wdata;

  function automatic logic wr_at(input logic [5:0] o);
    wr_at = i_io_wr && hit && (ofs == o);
  endfunction

  // Edge detection for latched sources
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      wake_src_prev_q <= 5'h00;
      gpio_prev_q <= 8'h00;
      wdt_prev_q <= 1'b0;
    end
    else
    begin
      wake_src_prev_q <= i_wake_src;
      gpio_prev_q <= i_gpio_evt;
      wdt_prev_q <= i_wdt_evt;
    end

  assign wake_rise = i_wake_src & ~wake_src_prev_q;
  assign gpio_rise = i_gpio_evt & ~gpio_prev_q;
  assign wdt_rise = i_wdt_evt & ~wdt_prev_q;

  // Firmware event pair
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      fw_sts_q <= RST_REG;
      fw_en_q <= RST_REG;
    end
    else
    begin
      fw_sts_q <= i_fw_event_set |
        (fw_sts_q & ~(wr_at(OFS_FW_STS) ? wd : 8'h00));
      if (wr_at(OFS_FW_EN))
        fw_en_q <= wd;
    end

  assign firmware_event_line = |(fw_sts_q & fw_en_q);

  assign wake_sts2 = {1'b0, i_intrusion, bat_bus.wake_low,
    firmware_event_line, i_mailbox_event_two, i_mailbox_event_one,
    wake_wdt_q, smi_group & sysmgmt_enable_second_q[BIT_TO_WAKE]};
  assign sysmgmt_status_first = {i_sio_smi, firmware_event_line,
    i_mailbox_event_two, i_mailbox_event_one};
  assign sysmgmt_status_second = {2'b00, bat_bus.smi_low, 4'h0, smi_wdt_q};

  // low flags act only on main rail
  always_comb
  begin
    wake_sts2_evt = wake_sts2;
    sysmgmt_status_second_evt = sysmgmt_status_second;
    wake_sts2_evt[BIT_LOW_BAT] = wake_sts2[BIT_LOW_BAT] & i_main_on;
    sysmgmt_status_second_evt[BIT_LOW_BAT] = sysmgmt_status_second[BIT_LOW_BAT] & i_main_on;
  end

  assign wake_pend = |(wake_sts1_q & wake_en1_q) |
    |(wake_sts2_evt & wake_en2_q) | |(wake_sts3_q & wake_en3_q);
  assign smi_pend = |(sysmgmt_status_first & sysmgmt_enable_first_q) |
    |(sysmgmt_status_second_evt & sysmgmt_enable_second_q & MASK_SYSMGMT_STATUS_SECOND) |
    |(sysmgmt_status_third_q & sysmgmt_enable_third_q);
  assign smi_group = smi_sum_q & smi_gen_q[BIT_SUM];

  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      wake_sts1_q <= RST_REG;
    else
      wake_sts1_q <= ({2'b00, wake_rise, 1'b0} |
        (wake_sts1_q & ~(wr_at(OFS_WAKE_STS1) ? wd : 8'h00))) &
        MASK_WAKE_STS1;

  // Latched watchdog and GPIO bits, set wins over clear
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      wake_wdt_q <= 1'b0;
      wake_sts3_q <= RST_REG;
      smi_wdt_q <= 1'b0;
      sysmgmt_status_third_q <= RST_REG;
    end
    else
    begin
      wake_wdt_q <= wdt_rise |
        (wake_wdt_q & ~(wr_at(OFS_WAKE_STS2) & wd[BIT_WDT]));
      wake_sts3_q <= gpio_rise |
        (wake_sts3_q & ~(wr_at(OFS_WAKE_STS3) ? wd : 8'h00));
      smi_wdt_q <= wdt_rise |
        (smi_wdt_q & ~(wr_at(OFS_SYSMGMT_STATUS_SECOND) & wd[0]));
      sysmgmt_status_third_q <= gpio_rise |
        (sysmgmt_status_third_q & ~(wr_at(OFS_SYSMGMT_STATUS_THIRD) ? wd : 8'h00));
    end

  assign bat_bus.wake_low_clr = wr_at(OFS_WAKE_STS2) & wd[BIT_LOW_BAT];
  assign bat_bus.smi_low_clr = wr_at(OFS_SYSMGMT_STATUS_SECOND) & wd[BIT_LOW_BAT];

  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      wake_summary_flag_q <= 1'b0;
    else
      wake_summary_flag_q <= wake_pend | (wake_summary_flag_q &
        ~(wr_at(OFS_WAKE_SUM) & wd[BIT_SUM]));

  // Sysmgmt summary latches the pending sysmgmt events, cleared by a bit 0 write
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      smi_sum_q <= 1'b0;
    else
      smi_sum_q <= smi_pend |
        (smi_sum_q & ~(wr_at(OFS_SMI_SUM) & wd[BIT_SUM]));

  // Wake global enable and first and third enables
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      wake_pin_enable_q <= 1'b0;
      wake_en1_q <= RST_REG;
      wake_en3_q <= RST_REG;
    end
    else
    begin
      if (wr_at(OFS_WAKE_GEN))
        wake_pin_enable_q <= wd[BIT_SUM];
      if (wr_at(OFS_WAKE_EN1))
        wake_en1_q <= wd & MASK_WAKE_STS1;
      if (wr_at(OFS_WAKE_EN3))
        wake_en3_q <= wd;
    end

  // Second wake enable; low-battery bit lost on standby rise
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      wake_en2_q <= RST_REG;
    else if (wr_at(OFS_WAKE_EN2))
      wake_en2_q <= wd & 8'h7f;
    else if (i_standby_rise)
      wake_en2_q[BIT_LOW_BAT] <= 1'b0;

  // Sysmgmt enables
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      smi_gen_q <= RST_REG;
      sysmgmt_enable_first_q <= RST_REG;
      sysmgmt_enable_second_q <= RST_REG;
      sysmgmt_enable_third_q <= RST_REG;
    end
    else
    begin
      if (wr_at(OFS_SMI_GEN))
        smi_gen_q <= wd & 8'h01;
      if (wr_at(OFS_SYSMGMT_ENABLE_FIRST))
        sysmgmt_enable_first_q <= wd;
      if (wr_at(OFS_SYSMGMT_ENABLE_SECOND))
        sysmgmt_enable_second_q <= wd;
      if (wr_at(OFS_SYSMGMT_ENABLE_THIRD))
        sysmgmt_enable_third_q <= wd;
    end

  // disk-change also reset by legacy reset
  assign disk_rst = i_rst | ~i_legacy_io_reset_n;

  always_ff @(posedge i_sys_clk or posedge disk_rst)
    if (disk_rst)
      disk_chg_q <= RST_REG;
    else if (wr_at(OFS_DISK_CHG))
      disk_chg_q <= wd;

  assign o_force_disk_change = disk_chg_q;

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rdata_d = 8'h00;
    case (ofs)
      OFS_WAKE_SUM: rdata_d = {7'h00, wake_summary_flag_q};
      OFS_WAKE_GEN: rdata_d = {7'h00, wake_pin_enable_q};
      OFS_WAKE_STS1: rdata_d = wake_sts1_q;
      OFS_WAKE_STS2: rdata_d = wake_sts2;
      OFS_WAKE_STS3: rdata_d = wake_sts3_q;
      OFS_WAKE_EN1: rdata_d = wake_en1_q;
      OFS_WAKE_EN2: rdata_d = wake_en2_q;
      OFS_WAKE_EN3: rdata_d = wake_en3_q;
      OFS_SMI_SUM: rdata_d = {7'h00, smi_sum_q};
      OFS_SMI_GEN: rdata_d = smi_gen_q;
      OFS_SYSMGMT_STATUS_FIRST: rdata_d = sysmgmt_status_first;
      OFS_SYSMGMT_STATUS_SECOND: rdata_d = sysmgmt_status_second;
      OFS_SYSMGMT_STATUS_THIRD: rdata_d = sysmgmt_status_third_q;
      OFS_SYSMGMT_ENABLE_FIRST: rdata_d = sysmgmt_enable_first_q;
      OFS_SYSMGMT_ENABLE_SECOND: rdata_d = sysmgmt_enable_second_q;
      OFS_SYSMGMT_ENABLE_THIRD: rdata_d = sysmgmt_enable_third_q;
      OFS_DISK_CHG: rdata_d = disk_chg_q;
      OFS_FW_STS: rdata_d = fw_sts_q;
      OFS_FW_EN: rdata_d = fw_en_q;
      default: rdata_d = 8'h00;
    endcase
    if (!hit)
      rdata_d = 8'h00;
  end

  // Read data one cycle after the strobe
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      o_io_rdata <= 8'h00;
      o_io_rvalid <= 1'b0;
    end
    else
    begin
      o_io_rvalid <= i_io_rd;
      if (i_io_rd)
        o_io_rdata <= rdata_d;
    end

  wsb_bat u_bat (
    .i_sys_clk(i_sys_clk),
    .i_vbat_rst(i_vbat_rst),
    .i_standby_on(i_standby_on),
    .i_standby_rise(i_standby_rise),
    .i_main_rise(i_main_rise),
    .i_bat_swap(i_bat_swap),
    .i_below_low(i_below_low),
    .i_below_high(i_below_high),
    .i_ec_por_clr(i_ec_por_clr),
    .bus(bat_bus.bat)
  );

  assign o_ec_por_flag = bat_bus.por_flag;

  wsb_irq_out u_wake_out (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_req(wake_summary_flag_q),
    .i_pin_en(wake_pin_enable_q),
    .i_serirq_en(wake_pin_enable_q),
    .o_pin_o(o_wake_event_pin_n_o),
    .o_pin_oe(o_wake_event_pin_n_oe),
    .o_serirq_n(o_serirq_n[0])
  );

  wsb_irq_out u_smi_out (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_req(smi_group),
    .i_pin_en(sysmgmt_enable_second_q[BIT_PIN_EN]),
    .i_serirq_en(sysmgmt_enable_second_q[BIT_SERIRQ_EN]),
    .o_pin_o(o_sysmgmt_irq_pin_n_o),
    .o_pin_oe(o_sysmgmt_irq_pin_n_oe),
    .o_serirq_n(o_serirq_n[1])
  );
endmodule
`default_nettype wire

// >>> verif/test_wsb_top.sv
// Self-checking bench for the wake, system-management and battery block
`timescale 1ns/1ps
`default_nettype none
module test_wsb_top;
  import wsb_pkg::*;
  localparam logic [15:0] BASE = 16'h0a00;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_vbat_rst = 1'b1;
  logic i_legacy_io_reset_n = 1'b1, i_standby_on = 1'b1, i_main_on = 1'b1;
  logic i_standby_rise = 1'b0, i_main_rise = 1'b0, i_bat_swap = 1'b0;
  logic i_below_low = 1'b0, i_below_high = 1'b0, i_ec_por_clr = 1'b0;
  logic i_mailbox_event_one = 1'b0, i_mailbox_event_two = 1'b0;
  logic [15:0] i_base_addr = BASE, i_io_addr;
  logic i_io_wr, i_io_rd, o_io_rvalid, o_ec_por_flag;
  logic [7:0] i_io_wdata, o_io_rdata, o_force_disk_change;
  logic [7:0] i_gpio_evt = 8'h00, i_fw_event_set = 8'h00;
  logic [4:0] i_wake_src = 5'h00;
  logic o_wake_event_pin_n_o, o_wake_event_pin_n_oe;
  logic o_sysmgmt_irq_pin_n_o, o_sysmgmt_irq_pin_n_oe;
  logic [1:0] o_serirq_n;
  logic [7:0] exp_q [$];
  int n_fail = 0, checked = 0;
  logic [5:0] reg_ofs [20] = '{OFS_WAKE_SUM, OFS_WAKE_GEN, OFS_WAKE_STS1,
    OFS_WAKE_STS2, OFS_WAKE_STS3, OFS_WAKE_EN1, OFS_WAKE_EN2, OFS_WAKE_EN3,
    OFS_SMI_SUM, OFS_SMI_GEN, OFS_SYSMGMT_STATUS_FIRST, OFS_SYSMGMT_STATUS_SECOND, OFS_SYSMGMT_STATUS_THIRD,
    OFS_SYSMGMT_ENABLE_FIRST, OFS_SYSMGMT_ENABLE_SECOND, OFS_SYSMGMT_ENABLE_THIRD, OFS_DISK_CHG, OFS_FW_STS,
    OFS_FW_EN, 6'h08};
  wsb_host_model #(.BASE(BASE)) wsb_host_model_inst (.i_sys_clk,
    .o_io_addr(i_io_addr), .o_io_wr(i_io_wr), .o_io_rd(i_io_rd),
    .o_io_wdata(i_io_wdata));
  // Watchdog, intrusion and legacy sources left quiet
  wsb_top wsb_top_inst (.i_sys_clk, .i_rst, .i_legacy_io_reset_n,
    .i_vbat_rst, .i_base_addr, .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata,
    .o_io_rdata, .o_io_rvalid, .i_standby_on, .i_standby_rise, .i_main_on,
    .i_main_rise, .i_bat_swap, .i_below_low, .i_below_high, .i_wake_src,
    .i_gpio_evt, .i_wdt_evt(1'b0), .i_intrusion(1'b0), .i_mailbox_event_one,
    .i_mailbox_event_two, .i_sio_smi(5'h00), .i_fw_event_set, .i_ec_por_clr,
    .o_ec_por_flag, .o_force_disk_change, .o_wake_event_pin_n_o,
    .o_wake_event_pin_n_oe, .o_sysmgmt_irq_pin_n_o, .o_sysmgmt_irq_pin_n_oe,
    .o_serirq_n);
  initial
  begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic final_report();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    idle(1);
    s = 1'b0;
    idle(1);
  endtask
  task automatic wr(input logic [5:0] ofs, input logic [7:0] d);
    wsb_host_model_inst.cycle(1'b1, ofs, d);
  endtask
  task automatic rd(input logic [5:0] ofs, input logic [7:0] exp);
    exp_q.push_back(exp);
    wsb_host_model_inst.cycle(1'b0, ofs, 8'h00);
  endtask
  // Read answers matched against the oldest note
  initial
  begin
    logic [7:0] exp_v;
    forever
    begin
      @(negedge i_sys_clk);
      if (o_io_rvalid === 1'b1)
      begin
        exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
        check(o_io_rdata, exp_v);
      end
    end
  end
  initial
  begin
    #100000;
    n_fail++;
    final_report();
  end
  initial
  begin : run
    logic [7:0] r;
    void'($urandom(49543));
    idle(4);
    i_rst = 1'b0;
    i_vbat_rst = 1'b0;
    foreach (reg_ofs[i])
      rd(reg_ofs[i], 8'h00);
    chk1(o_ec_por_flag, 1'b1);
    pulse(i_ec_por_clr);
    chk1(o_ec_por_flag, 1'b0);
    pulse(i_bat_swap);
    chk1(o_ec_por_flag, 1'b0);
    i_standby_on = 1'b0;
    i_main_on = 1'b0;
    pulse(i_bat_swap);
    chk1(o_ec_por_flag, 1'b1);
    pulse(i_ec_por_clr);
    wr(OFS_WAKE_EN2, 8'h20);
    wr(OFS_WAKE_GEN, 8'h01);
    i_below_low = 1'b1;
    i_standby_on = 1'b1;
    pulse(i_standby_rise);
    chk1(o_ec_por_flag, 1'b1);
    rd(OFS_WAKE_EN2, 8'h00);
    rd(OFS_WAKE_STS2, 8'h20);
    rd(OFS_SYSMGMT_STATUS_SECOND, 8'h20);
    wr(OFS_WAKE_EN2, 8'h20);
    idle(4);
    chk1(o_wake_event_pin_n_oe, 1'b0);
    rd(OFS_WAKE_SUM, 8'h00);
    i_main_on = 1'b1;
    pulse(i_main_rise);
    idle(3);
    chk1(o_wake_event_pin_n_oe, 1'b1);
    chk1(o_serirq_n[0], 1'b0);
    rd(OFS_WAKE_SUM, 8'h01);
    wr(OFS_WAKE_STS2, 8'h00);
    rd(OFS_WAKE_STS2, 8'h20);
    wr(OFS_WAKE_STS2, 8'h20);
    rd(OFS_WAKE_STS2, 8'h00);
    wr(OFS_SYSMGMT_STATUS_SECOND, 8'h20);
    wr(OFS_WAKE_SUM, 8'h01);
    idle(4);
    rd(OFS_WAKE_SUM, 8'h00);
    chk1(o_wake_event_pin_n_oe, 1'b0);
    // System reset mid-run must spare the battery-side flag
    pulse(i_rst);
    chk1(o_ec_por_flag, 1'b1);
    rd(OFS_WAKE_GEN, 8'h00);
    rd(OFS_WAKE_EN2, 8'h00);
    wr(OFS_WAKE_EN2, 8'h20);
    // Controller clears the battery-side reset flag
    pulse(i_ec_por_clr);
    i_below_high = 1'b1;
    idle(3);
    rd(OFS_WAKE_STS2, 8'h00);
    rd(OFS_WAKE_SUM, 8'h00);
    pulse(i_main_rise);
    rd(OFS_WAKE_STS2, 8'h20);
    rd(OFS_SYSMGMT_STATUS_SECOND, 8'h20);
    wr(OFS_WAKE_STS2, 8'h20);
    wr(OFS_SYSMGMT_STATUS_SECOND, 8'h20);
    wr(OFS_WAKE_EN2, 8'h00);
    wr(OFS_WAKE_SUM, 8'h01);
    wr(OFS_WAKE_GEN, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      i_wake_src = 5'h01 << k;
      idle(2);
      i_wake_src = 5'h00;
      idle(2);
      wr(OFS_WAKE_STS1, 8'h00);
      rd(OFS_WAKE_STS1, 8'h02 << k);
      rd(OFS_WAKE_SUM, 8'h00);
      wr(OFS_WAKE_EN1, 8'h3e);
      idle(3);
      rd(OFS_WAKE_SUM, 8'h01);
      chk1(o_wake_event_pin_n_oe, 1'b0);
      wr(OFS_WAKE_STS1, 8'h3e);
      wr(OFS_WAKE_EN1, 8'h00);
      wr(OFS_WAKE_SUM, 8'h00);
      rd(OFS_WAKE_SUM, 8'h01);
      wr(OFS_WAKE_SUM, 8'h01);
      rd(OFS_WAKE_SUM, 8'h00);
    end
    r = 8'($urandom());
    wr(OFS_WAKE_EN1, r);
    rd(OFS_WAKE_EN1, r & MASK_WAKE_STS1);
    wr(OFS_SYSMGMT_ENABLE_THIRD, r);
    rd(OFS_SYSMGMT_ENABLE_THIRD, r);
    wr(OFS_SYSMGMT_ENABLE_THIRD, 8'h00);
    wr(OFS_SYSMGMT_ENABLE_FIRST, 8'h03);
    wr(OFS_SMI_GEN, 8'h01);
    wr(OFS_SYSMGMT_ENABLE_SECOND, 8'hc0);
    for (int k = 0; k < 2; k++)
    begin
      {i_mailbox_event_two, i_mailbox_event_one} = 2'b01 << k;
      idle(4);
      chk1(o_sysmgmt_irq_pin_n_oe, 1'b1);
      chk1(o_serirq_n[1], 1'b0);
      rd(OFS_SYSMGMT_STATUS_FIRST, 8'h01 << k);
      rd(OFS_WAKE_STS2, 8'h04 << k);
      {i_mailbox_event_two, i_mailbox_event_one} = 2'b00;
      idle(2);
      rd(OFS_SYSMGMT_STATUS_FIRST, 8'h00);
      wr(OFS_SMI_SUM, 8'h01);
      idle(3);
      chk1(o_sysmgmt_irq_pin_n_oe, 1'b0);
    end
    r = 8'($urandom()) | 8'h01;
    i_fw_event_set = r;
    idle(1);
    i_fw_event_set = 8'h00;
    wr(OFS_FW_EN, r);
    rd(OFS_FW_STS, r);
    rd(OFS_SYSMGMT_STATUS_FIRST, 8'h04);
    rd(OFS_WAKE_STS2, 8'h10);
    wr(OFS_FW_STS, 8'hff);
    rd(OFS_SYSMGMT_STATUS_FIRST, 8'h00);
    i_gpio_evt = r;
    idle(3);
    rd(OFS_WAKE_STS3, r);
    rd(OFS_SYSMGMT_STATUS_THIRD, r);
    wr(OFS_DISK_CHG, r);
    rd(OFS_DISK_CHG, r);
    check(o_force_disk_change, r);
    i_legacy_io_reset_n = 1'b0;
    idle(1);
    i_legacy_io_reset_n = 1'b1;
    check(o_force_disk_change, 8'h00);
    rd(OFS_DISK_CHG, 8'h00);
    i_base_addr = BASE + 16'h0100;
    wr(OFS_DISK_CHG, 8'hff);
    i_base_addr = BASE;
    check(o_force_disk_change, 8'h00);
    rd(OFS_DISK_CHG, 8'h00);
    idle(5);
    final_report();
  end
endmodule
`default_nettype wire

// >>> verif/wsb_host_model.sv
// Host-side model issuing single-byte I/O cycles at offsets from a base
`timescale 1ns/1ps
`default_nettype none
module wsb_host_model #(
  parameter logic [15:0] BASE = 16'h0a00
) (
  // Clock
  input wire logic i_sys_clk,
  // I/O cycle toward the block
  output logic [15:0] o_io_addr,
  output logic o_io_wr,
  output logic o_io_rd,
  output logic [7:0] o_io_wdata
);
  initial
  begin
    o_io_addr = ~BASE;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_io_wdata = 8'h5a;
  end
  task automatic cycle(input logic wr, input logic [5:0] ofs,
    input logic [7:0] d);
    @(negedge i_sys_clk);
    o_io_addr = BASE + {10'h000, ofs};
    o_io_wdata = d;
    o_io_wr = wr;
    o_io_rd = !wr;
    @(negedge i_sys_clk);
    // Released lines carry junk, not the old value
    o_io_addr = ~o_io_addr;
    o_io_wdata = ~d;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/wsb_top_asserts.sv
// Port-level assertions for the wake and system-management block
`timescale 1ns/1ps
`default_nettype none
module wsb_top_asserts (
  // Clock and resets
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_legacy_io_reset_n,
  input wire logic i_vbat_rst,
  // Host access
  input wire logic [15:0] i_base_addr,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic [7:0] o_io_rdata,
  input wire logic o_io_rvalid,
  // Battery and power
  input wire logic i_standby_on,
  input wire logic i_standby_rise,
  input wire logic i_bat_swap,
  input wire logic i_below_low,
  input wire logic i_ec_por_clr,
  input wire logic o_ec_por_flag,
  input wire logic [7:0] o_force_disk_change,
  // Interrupt outputs
  input wire logic o_wake_event_pin_n_o,
  input wire logic o_wake_event_pin_n_oe,
  input wire logic o_sysmgmt_irq_pin_n_o,
  input wire logic o_sysmgmt_irq_pin_n_oe,
  input wire logic [1:0] o_serirq_n
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_read;
    i_io_rd ##1 o_io_rvalid;
  endsequence
  sequence s_swap_off;
    i_bat_swap && !i_standby_on && !i_ec_por_clr;
  endsequence
  property p_read_answer;
    i_io_rd && (i_io_addr - i_base_addr) < 16'h0040 |-> s_read;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered next cycle");
  property p_rdata_hold;
    !o_io_rvalid |-> $stable(o_io_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_reset_idle;
    $fell(i_rst) |-> o_serirq_n == 2'b11 && !o_io_rvalid
      && !o_wake_event_pin_n_oe && !o_sysmgmt_irq_pin_n_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  property p_wake_pin_serial;
    o_wake_event_pin_n_oe == !o_serirq_n[0] && !o_wake_event_pin_n_o
      && !o_sysmgmt_irq_pin_n_o;
  endproperty
  a_wake_pin_serial: assert property (p_wake_pin_serial)
    else $error("wake pin and serial level disagree");
  property p_swap_sets;
    s_swap_off |=> o_ec_por_flag;
  endproperty
  a_swap_sets: assert property (p_swap_sets)
    else $error("battery swap did not set flag");
  property p_swap_ignored;
    i_bat_swap && i_standby_on && !i_standby_rise && !i_vbat_rst
      && !o_ec_por_flag |=> !o_ec_por_flag;
  endproperty
  a_swap_ignored: assert property (p_swap_ignored)
    else $error("swap with standby on changed flag");
  property p_standby_low;
    i_standby_rise && i_below_low && !i_ec_por_clr |=> o_ec_por_flag;
  endproperty
  a_standby_low: assert property (p_standby_low)
    else $error("standby rise with low battery missed");
  property p_por_clear;
    i_ec_por_clr && !i_vbat_rst && !i_bat_swap && !i_standby_rise
      |=> !o_ec_por_flag;
  endproperty
  a_por_clear: assert property (p_por_clear)
    else $error("flag not cleared by controller");
  property p_disk_reset;
    !i_legacy_io_reset_n |-> o_force_disk_change == 8'h00;
  endproperty
  a_disk_reset: assert property (p_disk_reset)
    else $error("disk change not cleared");
endmodule
bind wsb_top wsb_top_asserts wsb_top_asserts_inst (.i_sys_clk, .i_rst,
  .i_legacy_io_reset_n, .i_vbat_rst, .i_base_addr, .i_io_addr, .i_io_rd,
  .o_io_rdata, .o_io_rvalid, .i_standby_on, .i_standby_rise, .i_bat_swap,
  .i_below_low, .i_ec_por_clr, .o_ec_por_flag, .o_force_disk_change,
  .o_wake_event_pin_n_o, .o_wake_event_pin_n_oe, .o_sysmgmt_irq_pin_n_o,
  .o_sysmgmt_irq_pin_n_oe, .o_serirq_n);
`default_nettype wire
